// file: design/mscb_consts.vh
// Constants for the MAC statistics counter bank
`ifndef MSCB_CONSTS_VH
`define MSCB_CONSTS_VH

// Management address width and counter window
`define MSCB_ADDR_W              12
`define MSCB_CNT_BASE            12'h200
`define MSCB_CNT_LAST            12'h23c

// Register offsets, lower word first, upper word at offset plus four
`define MSCB_RX_BYTE_COUNT_LOW       12'h200
`define MSCB_RX_BYTE_COUNT_HIGH      12'h204
`define MSCB_TX_BYTE_COUNT_LOW       12'h208
`define MSCB_TX_BYTE_COUNT_HIGH      12'h20c
`define MSCB_RX_SHORT_FRAMES_LOW     12'h210
`define MSCB_RX_SHORT_FRAMES_HIGH    12'h214
`define MSCB_RX_RUNT_BAD_CRC_LOW     12'h218
`define MSCB_RX_RUNT_BAD_CRC_HIGH    12'h21c
`define MSCB_RX_LEN64_OK_LOW         12'h220
`define MSCB_RX_LEN64_OK_HIGH        12'h224
`define MSCB_RX_LEN65_127_OK_LOW     12'h228
`define MSCB_RX_LEN65_127_OK_HIGH    12'h22c
`define MSCB_RX_LEN128_255_OK_LOW    12'h230
`define MSCB_RX_LEN128_255_OK_HIGH   12'h234
`define MSCB_RX_LEN256_511_OK_LOW    12'h238
`define MSCB_RX_LEN256_511_OK_HIGH   12'h23c

// Field positions inside a counter address
`define MSCB_HALF_BIT            2
`define MSCB_IDX_MSB             5
`define MSCB_IDX_LSB             3

// AXI4-Lite response codes
`define MSCB_RESP_OKAY           2'b00
`define MSCB_RESP_SLVERR         2'b10
`define MSCB_RESP_DECERR         2'b11

// Frame length limits in bytes
`define MSCB_LEN_64              15'h0040
`define MSCB_LEN_127             15'h007f
`define MSCB_LEN_255             15'h00ff
`define MSCB_LEN_511             15'h01ff

// Cycles of the system clock before lock is reported
`define MSCB_LOCK_CYCLES         4'hf

`endif

// file: design/mscb_counter_mem.v
// Eight 64-bit wraparound statistics counters with a registered read port
`timescale 1ns/1ns
module mscb_counter_mem (
	input  wire        clock_in,       // System clock
	input  wire [3:0]  rx_add_in,      // Receive bytes this cycle
	input  wire [3:0]  tx_add_in,      // Transmit bytes this cycle
	input  wire [5:0]  frame_inc_in,   // One-cycle increments, counters 2 to 7
	input  wire [2:0]  rd_idx_in,      // Counter to read
	output wire [63:0] rd_data_out     // Registered counter value
);

	reg [63:0] cnt_mem [0:7];
	reg [63:0] rd_data_reg;
	integer    i;

	function [63:0] mscb_wrap_add;
		input [63:0] value;
		input [3:0]  delta;
		begin
			mscb_wrap_add = value + {60'h0, delta};
		end
	endfunction

	// Counters start at zero on configuration only
	initial begin
		for (i = 0; i < 8; i = i + 1) begin
			cnt_mem[i] = 64'h0;
		end
	end

	// No reset: the core reset leaves the counts alone; sums wrap to zero
	always @(posedge clock_in) begin                                        // [RULE1]
		rd_data_reg <= cnt_mem[rd_idx_in];                                  // [RULE2]
		cnt_mem[0]  <= mscb_wrap_add(cnt_mem[0], rx_add_in);                // [RULE7]
		cnt_mem[1]  <= mscb_wrap_add(cnt_mem[1], tx_add_in);                // [RULE8]
		for (i = 2; i < 8; i = i + 1) begin
			if (frame_inc_in[i-2]) begin
				cnt_mem[i] <= mscb_wrap_add(cnt_mem[i], 4'h1);
			end
		end
	end

	assign rd_data_out = rd_data_reg;

endmodule // mscb_counter_mem

// file: design/mscb_stats_bank.v
// MAC statistics counter bank with AXI4-Lite read access and transmit clock generation
// Functional notes
// (RULE1) Counters wrap to zero on overflow and ignore the core reset.
// (RULE2) Reads never clear a counter; only wrap or reconfiguration zero it.
// (RULE3) Writes to counters answer SLVERR and change nothing.
// (RULE4) Upper word read without prior lower word read answers SLVERR.
// (RULE5) Upper word returned matches the snapshot taken at the lower word read.
// (RULE6) Other accesses may come between lower and upper word reads.
// (RULE7) Received bytes counter sums every received byte, address through FCS.
// (RULE8) Transmitted bytes counter sums every transmitted byte, address through FCS.
// (RULE9) Undersize counter counts good-FCS received frames shorter than 64 bytes.
// (RULE10) Fragment counter counts received frames under 64 bytes with bad FCS.
// (RULE11) Counts error-free received frames of exactly 64 bytes.
// (RULE12) Counts error-free received frames of 65 to 127 bytes.
// (RULE13) Counts error-free received frames of 128 to 255 bytes.
// (RULE14) Counts error-free received frames of 256 to 511 bytes.
// (RULE15) Core reset is asynchronous and synchronised inside the core.
// (RULE16) Transmit and receive statistics are updated by separate logic.
// (RULE17) The transmit system clock is derived from the system clock input.
// (RULE18) A 90 degree shifted transmit clock and a lock status are provided.
// (RULE19) Frame fields count on the valid strobe; byte counts count every cycle.
// (RULE20) Each counter takes two words: lower at offset, upper at offset plus four.
// (RULE21) Counter values are captured whole in one cycle so reads stay coherent.
`timescale 1ns/1ns
`include "mscb_consts.vh"
module mscb_stats_bank (
	input  wire        clock_in,                       // System clock
	input  wire        rst_n_in,                       // Asynchronous reset, active low
	input  wire [11:0] s_axi_awaddr_in,                // Write address
	input  wire        s_axi_awvalid_in,               // Write address valid
	output wire        s_axi_awready_out,              // Write address ready
	input  wire [31:0] s_axi_wdata_in,                 // Write data
	input  wire [3:0]  s_axi_wstrb_in,                 // Write strobes
	input  wire        s_axi_wvalid_in,                // Write data valid
	output wire        s_axi_wready_out,               // Write data ready
	output wire [1:0]  s_axi_bresp_out,                // Write response
	output wire        s_axi_bvalid_out,               // Write response valid
	input  wire        s_axi_bready_in,                // Write response ready
	input  wire [11:0] s_axi_araddr_in,                // Read address
	input  wire        s_axi_arvalid_in,               // Read address valid
	output wire        s_axi_arready_out,              // Read address ready
	output wire [31:0] s_axi_rdata_out,                // Read data
	output wire [1:0]  s_axi_rresp_out,                // Read response
	output wire        s_axi_rvalid_out,               // Read data valid
	input  wire        s_axi_rready_in,                // Read data ready
	input  wire        rx_stats_valid_in,              // Receive frame fields valid
	input  wire [3:0]  rx_bytes_valid_in,              // Receive bytes this cycle, 0 to 8
	input  wire [14:0] rx_frame_length_in,             // Received frame length in bytes
	input  wire        rx_good_frame_in,               // Received frame error free
	input  wire        rx_fcs_error_in,                // Received frame FCS bad
	input  wire [3:0]  tx_bytes_valid_in,              // Transmit bytes this cycle, 0 to 8
	output wire        transmit_system_clock_out,      // Derived transmit clock
	output wire        transmit_clock_quadrature_out,  // Transmit clock shifted 90 degrees
	output wire        tx_clock_locked_out             // Derived clocks stable
);

	localparam [5:0] ST_IDLE  = 6'b000001;
	localparam [5:0] ST_RACC  = 6'b000010;
	localparam [5:0] ST_RMEM  = 6'b000100;
	localparam [5:0] ST_RRESP = 6'b001000;
	localparam [5:0] ST_WACC  = 6'b010000;
	localparam [5:0] ST_WRESP = 6'b100000;

	// Returns {hit, upper half, counter index}
	function [4:0] mscb_decode;
		input [11:0] addr;
		begin
			if (addr >= `MSCB_CNT_BASE && addr <= `MSCB_CNT_LAST && addr[1:0] == 2'b00) begin
				mscb_decode = {1'b1, addr[`MSCB_HALF_BIT], addr[`MSCB_IDX_MSB:`MSCB_IDX_LSB]}; // [RULE20]
			end else begin
				mscb_decode = 5'h00;
			end
		end
	endfunction

	reg        rst_sync1_reg;
	reg        rst_sync2_reg;
	reg [5:0]  state_reg;
	reg [5:0]  state_next;
	reg [11:0] addr_reg;
	reg [11:0] addr_next;
	reg        arready_reg;
	reg        arready_next;
	reg        awready_reg;
	reg        awready_next;
	reg        wready_reg;
	reg        wready_next;
	reg        bvalid_reg;
	reg        bvalid_next;
	reg [1:0]  bresp_reg;
	reg [1:0]  bresp_next;
	reg        rvalid_reg;
	reg        rvalid_next;
	reg [1:0]  rresp_reg;
	reg [1:0]  rresp_next;
	reg [31:0] rdata_reg;
	reg [31:0] rdata_next;
	reg [7:0]  snap_valid_reg;
	reg [7:0]  snap_valid_next;
	reg [31:0] snap_high_mem [0:7];
	reg        snap_load;
	reg [3:0]  rx_add_reg;
	reg [3:0]  tx_add_reg;
	reg [5:0]  frame_inc_reg;
	reg [5:0]  frame_inc_next;
	reg [1:0]  clk_phase_reg;
	reg        tx_clk_reg;
	reg        transmit_clock_quadrature_reg;
	reg [3:0]  lock_cnt_reg;
	reg        locked_reg;

	wire       rst_n_sync;
	wire [4:0] addr_dec;
	wire       addr_hit;
	wire       addr_high;
	wire [2:0] addr_idx;
	wire [63:0] mem_rd_data;
	wire       len_under_64;

	// Reset is released synchronously to the clock
	always @(posedge clock_in or negedge rst_n_in) begin                   // [RULE15]
		if (!rst_n_in) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end

	assign rst_n_sync = rst_sync2_reg;

	assign addr_dec  = mscb_decode(addr_reg);
	assign addr_hit  = addr_dec[4];
	assign addr_high = addr_dec[3];
	assign addr_idx  = addr_dec[2:0];

	mscb_counter_mem u_counter_mem (
		.clock_in     (clock_in),
		.rx_add_in    (rx_add_reg),
		.tx_add_in    (tx_add_reg),
		.frame_inc_in (frame_inc_reg),
		.rd_idx_in    (addr_idx),
		.rd_data_out  (mem_rd_data)
	);

	// Management bus state machine
	always @* begin
		state_next      = state_reg;
		addr_next       = addr_reg;
		arready_next    = 1'b0;
		awready_next    = 1'b0;
		wready_next     = 1'b0;
		bvalid_next     = bvalid_reg;
		bresp_next      = bresp_reg;
		rvalid_next     = rvalid_reg;
		rresp_next      = rresp_reg;
		rdata_next      = rdata_reg;
		snap_valid_next = snap_valid_reg;
		snap_load       = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (s_axi_arvalid_in) begin
					arready_next = 1'b1;
					addr_next    = s_axi_araddr_in;
					state_next   = ST_RACC;
				end else if (s_axi_awvalid_in && s_axi_wvalid_in) begin
					awready_next = 1'b1;
					wready_next  = 1'b1;
					addr_next    = s_axi_awaddr_in;
					state_next   = ST_WACC;
				end
			end
			ST_RACC: begin
				state_next = ST_RMEM;
			end
			ST_RMEM: begin
				rvalid_next = 1'b1;
				state_next  = ST_RRESP;
				if (!addr_hit) begin
					rdata_next = 32'h0;
					rresp_next = `MSCB_RESP_DECERR;
				end else if (!addr_high) begin
					rdata_next                = mem_rd_data[31:0];     // [RULE2]
					rresp_next                = `MSCB_RESP_OKAY;
					snap_load                 = 1'b1;                  // [RULE21]
					snap_valid_next[addr_idx] = 1'b1;                  // [RULE6]
				end else if (snap_valid_reg[addr_idx]) begin
					rdata_next                = snap_high_mem[addr_idx]; // [RULE5]
					rresp_next                = `MSCB_RESP_OKAY;
					snap_valid_next[addr_idx] = 1'b0;
				end else begin
					rdata_next = 32'h0;
					rresp_next = `MSCB_RESP_SLVERR;                    // [RULE4]
				end
			end
			ST_RRESP: begin
				if (s_axi_rready_in) begin
					rvalid_next = 1'b0;
					state_next  = ST_IDLE;
				end
			end
			ST_WACC: begin
				bvalid_next = 1'b1;
				state_next  = ST_WRESP;
				if (addr_hit) begin
					bresp_next = `MSCB_RESP_SLVERR;                    // [RULE3]
				end else begin
					bresp_next = `MSCB_RESP_DECERR;
				end
			end
			ST_WRESP: begin
				if (s_axi_bready_in) begin
					bvalid_next = 1'b0;
					state_next  = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clock_in or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg      <= ST_IDLE;
			addr_reg       <= 12'h000;
			arready_reg    <= 1'b0;
			awready_reg    <= 1'b0;
			wready_reg     <= 1'b0;
			bvalid_reg     <= 1'b0;
			bresp_reg      <= `MSCB_RESP_OKAY;
			rvalid_reg     <= 1'b0;
			rresp_reg      <= `MSCB_RESP_OKAY;
			rdata_reg      <= 32'h0;
			snap_valid_reg <= 8'h00;
		end else begin
			state_reg      <= state_next;
			addr_reg       <= addr_next;
			arready_reg    <= arready_next;
			awready_reg    <= awready_next;
			wready_reg     <= wready_next;
			bvalid_reg     <= bvalid_next;
			bresp_reg      <= bresp_next;
			rvalid_reg     <= rvalid_next;
			rresp_reg      <= rresp_next;
			rdata_reg      <= rdata_next;
			snap_valid_reg <= snap_valid_next;
		end
	end

	// Upper half held from the same cycle as the lower half returned
	always @(posedge clock_in) begin
		if (snap_load) begin
			snap_high_mem[addr_idx] <= mem_rd_data[63:32];                  // [RULE5]
		end
	end

	assign len_under_64 = rx_frame_length_in < `MSCB_LEN_64;

	// Receive frame classification, qualified by the valid strobe
	always @* begin
		frame_inc_next = 6'h00;
		if (rx_stats_valid_in) begin                                        // [RULE19]
			frame_inc_next[0] = len_under_64 && !rx_fcs_error_in;           // [RULE9]
			frame_inc_next[1] = len_under_64 && rx_fcs_error_in;            // [RULE10]
			if (rx_good_frame_in) begin
				frame_inc_next[2] = rx_frame_length_in == `MSCB_LEN_64;     // [RULE11]
				frame_inc_next[3] = rx_frame_length_in > `MSCB_LEN_64 &&
					rx_frame_length_in <= `MSCB_LEN_127;                    // [RULE12]
				frame_inc_next[4] = rx_frame_length_in > `MSCB_LEN_127 &&
					rx_frame_length_in <= `MSCB_LEN_255;                    // [RULE13]
				frame_inc_next[5] = rx_frame_length_in > `MSCB_LEN_255 &&
					rx_frame_length_in <= `MSCB_LEN_511;                    // [RULE14]
			end
		end
	end

	// Receive side statistics stage
	always @(posedge clock_in or negedge rst_n_sync) begin                 // [RULE16]
		if (!rst_n_sync) begin
			rx_add_reg    <= 4'h0;
			frame_inc_reg <= 6'h00;
		end else begin
			rx_add_reg    <= rx_bytes_valid_in;                             // [RULE7]
			frame_inc_reg <= frame_inc_next;
		end
	end

	// Transmit side statistics stage
	always @(posedge clock_in or negedge rst_n_sync) begin                 // [RULE16]
		if (!rst_n_sync) begin
			tx_add_reg <= 4'h0;
		end else begin
			tx_add_reg <= tx_bytes_valid_in;                                // [RULE8]
		end
	end

	// Gray phase counter gives a quarter-rate clock and its 90 degree copy
	always @(posedge clock_in or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			clk_phase_reg <= 2'b00;
			tx_clk_reg    <= 1'b0;
			transmit_clock_quadrature_reg  <= 1'b0;
			lock_cnt_reg  <= 4'h0;
			locked_reg    <= 1'b0;
		end else begin
			clk_phase_reg <= {clk_phase_reg[0], ~clk_phase_reg[1]};        // [RULE17]
			tx_clk_reg    <= clk_phase_reg[1];                              // [RULE17]
			transmit_clock_quadrature_reg  <= clk_phase_reg[0];                              // [RULE18]
			if (lock_cnt_reg != `MSCB_LOCK_CYCLES) begin
				lock_cnt_reg <= lock_cnt_reg + 4'h1;
			end else begin
				locked_reg <= 1'b1;                                         // [RULE18]
			end
		end
	end

	assign s_axi_awready_out             = awready_reg;
	assign s_axi_wready_out              = wready_reg;
	assign s_axi_bresp_out               = bresp_reg;
	assign s_axi_bvalid_out              = bvalid_reg;
	assign s_axi_arready_out             = arready_reg;
	assign s_axi_rdata_out               = rdata_reg;
	assign s_axi_rresp_out               = rresp_reg;
	assign s_axi_rvalid_out              = rvalid_reg;
	assign transmit_system_clock_out     = tx_clk_reg;
	assign transmit_clock_quadrature_out = transmit_clock_quadrature_reg;
	assign tx_clock_locked_out           = locked_reg;

endmodule // mscb_stats_bank

// file: test/mscb_stats_bank_asserts.sv
// Port-level assertions for the statistics counter bank
`timescale 1ns/1ns
`include "mscb_consts.vh"
module mscb_stats_bank_asserts (
	input wire        clock_in,                      // System clock
	input wire        rst_n_in,                      // Reset, active low
	input wire [11:0] s_axi_awaddr_in,               // Write address
	input wire        s_axi_awready_out,             // Write address ready
	input wire        s_axi_wready_out,              // Write data ready
	input wire [1:0]  s_axi_bresp_out,               // Write response
	input wire        s_axi_bvalid_out,              // Write response valid
	input wire        s_axi_bready_in,               // Write response ready
	input wire [11:0] s_axi_araddr_in,               // Read address
	input wire        s_axi_arready_out,             // Read address ready
	input wire [31:0] s_axi_rdata_out,               // Read data
	input wire [1:0]  s_axi_rresp_out,               // Read response
	input wire        s_axi_rvalid_out,              // Read data valid
	input wire        s_axi_rready_in,               // Read data ready
	input wire        transmit_system_clock_out,     // Derived clock
	input wire        transmit_clock_quadrature_out  // Shifted clock
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	wire aw_cnt = (s_axi_awaddr_in >= `MSCB_CNT_BASE) && (s_axi_awaddr_in <= `MSCB_CNT_LAST) &&
		(s_axi_awaddr_in[1:0] == 2'b00);
	wire ar_map = (s_axi_araddr_in >= `MSCB_CNT_BASE) && (s_axi_araddr_in <= `MSCB_CNT_LAST) &&
		(s_axi_araddr_in[1:0] == 2'b00);
	sequence rd_walk_s;
		!s_axi_arready_out ##1 s_axi_rvalid_out;
	endsequence
	sequence div_s;
		transmit_system_clock_out ##1 !transmit_system_clock_out ##1 !transmit_system_clock_out;
	endsequence
	rd_answer_a: assert property (s_axi_arready_out |=> rd_walk_s)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data not held");
	rd_unmapped_a: assert property (s_axi_arready_out && !ar_map |-> ##2 s_axi_rresp_out == `MSCB_RESP_DECERR && s_axi_rdata_out == 32'h0)
		else $error("unmapped read not refused");
	wr_pair_a: assert property (s_axi_awready_out == s_axi_wready_out)
		else $error("write readies apart");
	wr_answer_a: assert property (s_axi_awready_out |=> s_axi_bvalid_out && !s_axi_awready_out)
		else $error("write answer late");
	wr_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response not held");
	wr_slverr_a: assert property (s_axi_awready_out && aw_cnt |=> s_axi_bresp_out == `MSCB_RESP_SLVERR)
		else $error("counter write not SLVERR");
	wr_decerr_a: assert property (s_axi_awready_out && !aw_cnt |=> s_axi_bresp_out == `MSCB_RESP_DECERR)
		else $error("unmapped write not DECERR");
	clk_div_a: assert property ($rose(transmit_system_clock_out) |=> div_s)
		else $error("transmit clock not divided by four");
	clk_quad_a: assert property ($rose(transmit_clock_quadrature_out) |=> $rose(transmit_system_clock_out))
		else $error("quadrature clock not one cycle ahead");
endmodule // mscb_stats_bank_asserts
bind mscb_stats_bank mscb_stats_bank_asserts i_chk (.*);

// file: test/mscb_frame_src.sv
// Receive datapath model feeding the receive statistics inputs
`timescale 1ns/1ns
module mscb_frame_src (
	input  wire        clock_in,   // System clock
	input  wire        go_in,      // Start one frame
	input  wire [14:0] len_in,     // Frame length, held while busy
	input  wire        good_in,    // Frame error free
	input  wire        fcs_in,     // Frame FCS bad
	output reg         busy_out,   // Frame in progress
	output reg         valid_out,  // Frame fields valid
	output reg  [3:0]  bytes_out,  // Bytes this cycle
	output reg  [14:0] flen_out,   // Frame length field
	output reg         good_out,   // Good field
	output reg         fcs_out     // FCS error field
);
	reg [14:0] rem_reg;
	initial begin
		{busy_out, valid_out, bytes_out, flen_out, good_out, fcs_out, rem_reg} = 0;
	end
	always @(posedge clock_in) begin
		valid_out <= 1'b0;
		bytes_out <= 4'h0;
		flen_out  <= ~flen_out;  // Fields toggle outside the strobe
		good_out  <= ~good_out;
		fcs_out   <= ~fcs_out;
		if (go_in) begin
			rem_reg  <= len_in;
			busy_out <= 1'b1;
		end else if (busy_out && rem_reg == 15'h0) begin
			busy_out  <= 1'b0;
			valid_out <= 1'b1;
			flen_out  <= len_in;
			good_out  <= good_in;
			fcs_out   <= fcs_in;
		end else if (busy_out) begin
			bytes_out <= (rem_reg > 15'h8) ? 4'h8 : rem_reg[3:0];
			rem_reg   <= (rem_reg > 15'h8) ? rem_reg - 15'h8 : 15'h0;
		end
	end
endmodule // mscb_frame_src

// file: test/mscb_stats_bank_tb.sv
// Self-checking testbench for the statistics counter bank
`timescale 1ns/1ns
`include "mscb_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
	$display("Error %0t: got %h expected %h", $time, a, b); end end
module mscb_stats_bank_tb;
	reg         clock_in, rst_n_in, awvalid, wvalid, bready, arvalid, rready, go, fgood, ffcs;
	reg  [11:0] awaddr, araddr;
	reg  [14:0] flen;
	wire        awready, wready, bvalid, arready, rvalid, sv, busy, good, fcs, tsc, quad, locked;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [3:0]  nb;
	wire [14:0] slen;
	reg  [63:0] exp_cnt [0:7];
	reg  [63:0] hold;
	reg  [3:0]  tnb;
	reg  [31:0] d;
	reg  [1:0]  r;
	integer     err_total, n_tests, cyc, k;
	mscb_stats_bank i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(32'h5a5a_a5a5),
		.s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .rx_stats_valid_in(sv), .rx_bytes_valid_in(nb),
		.rx_frame_length_in(slen), .rx_good_frame_in(good), .rx_fcs_error_in(fcs),
		.tx_bytes_valid_in(tnb), .transmit_system_clock_out(tsc),
		.transmit_clock_quadrature_out(quad), .tx_clock_locked_out(locked));
	mscb_frame_src i_src (.clock_in(clock_in), .go_in(go), .len_in(flen), .good_in(fgood),
		.fcs_in(ffcs), .busy_out(busy), .valid_out(sv), .bytes_out(nb), .flen_out(slen),
		.good_out(good), .fcs_out(fcs));
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	task finish_test;
		begin
			$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	always @(posedge clock_in) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			err_total++;
			finish_test;
		end
	end
	// Transmit side moves one byte on the cycle after each cycle that the receive side moves any
	always @(posedge clock_in) begin
		tnb <= {3'h0, nb != 4'h0};
	end
	task rd(input [11:0] a);
		integer n;
		begin
			@(posedge clock_in);
			araddr  <= a;
			arvalid <= 1'b1;
			rready  <= 1'b1;
			n = 0;
			do begin @(negedge clock_in); n++; end while (arready !== 1'b1 && n < 40);
			`CHK(arready, 1'b1)
			@(posedge clock_in);
			arvalid <= 1'b0;
			n = 0;
			do begin @(negedge clock_in); n++; end while (rvalid !== 1'b1 && n < 40);
			`CHK(rvalid, 1'b1)
			d = rdata;
			r = rresp;
			@(posedge clock_in);
			rready <= 1'b0;
		end
	endtask
	task wr(input [11:0] a);
		integer n;
		begin
			@(posedge clock_in);
			awaddr  <= a;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
			n = 0;
			do begin @(negedge clock_in); n++; end while (awready !== 1'b1 && n < 40);
			`CHK(awready, 1'b1)
			@(posedge clock_in);
			awvalid <= 1'b0;
			wvalid  <= 1'b0;
			n = 0;
			do begin @(negedge clock_in); n++; end while (bvalid !== 1'b1 && n < 40);
			`CHK(bvalid, 1'b1)
			r = bresp;
			@(posedge clock_in);
			bready <= 1'b0;
		end
	endtask
	task frame(input [14:0] len, input g, input f);
		integer n;
		begin
			@(posedge clock_in);
			{go, flen, fgood, ffcs} <= {1'b1, len, g, f};
			@(posedge clock_in);
			go <= 1'b0;
			n = 0;
			do begin @(negedge clock_in); n++; end while (busy !== 1'b0 && n < 200);
			`CHK(busy, 1'b0)
			repeat (3) @(posedge clock_in);
			exp_cnt[0] += len;
			exp_cnt[1] += (len + 7) / 8;  // One transmit byte per cycle with receive bytes
			if (len < 64 && !f) exp_cnt[2] += 1;
			if (len < 64 && f) exp_cnt[3] += 1;
			if (g && len == 64) exp_cnt[4] += 1;
			if (g && len >= 65 && len <= 127) exp_cnt[5] += 1;
			if (g && len >= 128 && len <= 255) exp_cnt[6] += 1;
			if (g && len >= 256 && len <= 511) exp_cnt[7] += 1;
		end
	endtask
	task check_all;
		begin
			for (k = 0; k < 8; k++) begin
				rd(12'h200 + 12'(8 * k));
				`CHK({r, d}, {`MSCB_RESP_OKAY, exp_cnt[k][31:0]})
				rd(12'h204 + 12'(8 * k));
				`CHK({r, d}, {`MSCB_RESP_OKAY, exp_cnt[k][63:32]})
			end
		end
	endtask
	task reset_dut;
		begin
			@(posedge clock_in);
			rst_n_in <= 1'b0;
			repeat (4) @(posedge clock_in);
			`CHK({arready, rvalid, bvalid, locked}, 4'h0)
			rst_n_in <= 1'b1;
			repeat (3) @(posedge clock_in);
		end
	endtask
	initial begin
		{rst_n_in, awvalid, wvalid, bready, arvalid, rready, go, fgood, ffcs} = 0;
		{awaddr, araddr, flen, err_total, n_tests, cyc, tnb} = 0;
		for (k = 0; k < 8; k++) exp_cnt[k] = 64'h0;
		reset_dut;
		`CHK(locked, 1'b0)
		frame(15'd40, 1'b1, 1'b0);
		frame(15'd63, 1'b0, 1'b1);
		frame(15'd64, 1'b1, 1'b0);
		frame(15'd65, 1'b1, 1'b0);
		frame(15'd127, 1'b1, 1'b0);
		frame(15'd128, 1'b1, 1'b0);
		frame(15'd255, 1'b1, 1'b0);
		frame(15'd256, 1'b1, 1'b0);
		frame(15'd511, 1'b1, 1'b0);
		frame(15'd512, 1'b1, 1'b0);
		frame(15'd300, 1'b0, 1'b1);
		`CHK(locked, 1'b1)
		check_all;
		check_all;
		rd(`MSCB_RX_RUNT_BAD_CRC_HIGH);
		`CHK({r, d}, {`MSCB_RESP_SLVERR, 32'h0})
		rd(`MSCB_RX_BYTE_COUNT_LOW);
		`CHK(d, exp_cnt[0][31:0])
		hold = exp_cnt[0];
		frame(15'd100, 1'b1, 1'b0);
		rd(12'h100);
		`CHK({r, d}, {`MSCB_RESP_DECERR, 32'h0})
		wr(`MSCB_TX_BYTE_COUNT_LOW);
		`CHK(r, `MSCB_RESP_SLVERR)
		rd(`MSCB_RX_BYTE_COUNT_HIGH);
		`CHK({r, d}, {`MSCB_RESP_OKAY, hold[63:32]})
		rd(`MSCB_RX_BYTE_COUNT_HIGH);
		`CHK(r, `MSCB_RESP_SLVERR)
		wr(`MSCB_RX_LEN256_511_OK_HIGH);
		`CHK(r, `MSCB_RESP_SLVERR)
		wr(12'h100);
		`CHK(r, `MSCB_RESP_DECERR)
		check_all;
		reset_dut;
		check_all;
		finish_test;
	end
endmodule // mscb_stats_bank_tb
